/* spi_fmt_asserts.sv */
// Bus and pin checks for the format block
`timescale 1ns/1ns
`include "spi_fmt_params.svh"
module spi_fmt_asserts #(
  parameter int NUM_SELECTS = 4
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic COPO_OE,
  input wire logic LANE0_OE,
  input wire logic LANE1_OE,
  input wire logic [NUM_SELECTS-1:0] SELECT_OUT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);
  a_ack_on_time: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I && !WB_ACK_O))
    else $error("ack without request");
  a_fmt_reserved: assert property (
    WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == `ADDR_FORMAT
    |-> (WB_DAT_O & ~`FMT_WRITE_MASK) == 32'h0)
    else $error("reserved format bits not zero");
  a_unmapped_zero: assert property (
    WB_ACK_O && !$past(WB_WE_I) && !($past(WB_ADR_I) inside {8'h04, 8'h08, 8'h0c, 8'h14})
    |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_lane_pair: assert property (LANE0_OE == LANE1_OE)
    else $error("dual lanes driven apart");
  a_one_driver: assert property (!(COPO_OE && (LANE0_OE || LANE1_OE)))
    else $error("output line and lanes driven together");
  a_sel_reset: assert property (!$past(NRST) |-> SELECT_OUT == '1)
    else $error("select lines not idle high after reset");
endmodule : spi_fmt_asserts
bind spi_fmt_top spi_fmt_asserts #(.NUM_SELECTS(NUM_SELECTS)) u_chk (.MCLK, .NRST,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .COPO_OE,
  .LANE0_OE, .LANE1_OE, .SELECT_OUT);

/* spi_fmt_fifo.sv */
// Small valid/ready FIFO for transmit words
`timescale 1ns/1ns
module spi_fmt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t st_q;
  fifo_st_t st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
  end
  assign in_ready = st_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_q.cnt != '0;
  assign out_data = mem[st_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = st_q.wp + 1'b1;
    if (pop) st_d.rp = st_q.rp + 1'b1;
    if (push && !pop) st_d.cnt = st_q.cnt + 1'b1;
    if (pop && !push) st_d.cnt = st_q.cnt - 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[st_q.wp] <= in_data;
  end
endmodule : spi_fmt_fifo

/* spi_fmt_params.svh */
// Register offsets, field positions and timing constants of the format block
`ifndef SPI_FMT_PARAMS_SVH
`define SPI_FMT_PARAMS_SVH
`define ADDR_CONTROL 8'h04
`define ADDR_XFER_COUNT 8'h08
`define ADDR_FORMAT 8'h0c
`define ADDR_STATUS 8'h14
`define CTL_MODE_BIT 1
`define FMT_POL_HI 19
`define FMT_POL_LO 16
`define FMT_ONE_LINE_BIT 15
`define FMT_LANES_HI 13
`define FMT_LANES_LO 12
`define FMT_CHAR_HI 11
`define FMT_CHAR_LO 8
`define FMT_FB_INV_BIT 4
`define FMT_WRITE_MASK 32'h000fbf10
`define FMT_RESET 32'h00000000
`define CHAR_LEN_ZERO_BITS 5'h10
`define LANES_SINGLE 2'h0
`define LANES_DUAL 2'h1
`define FB_INV_RATE_MHZ 20
`define FIFO_DEPTH_WORDS 4
`endif

/* spi_fmt_partner.sv */
// Behavioural far-side SPI device
`timescale 1ns/1ns
module spi_fmt_partner (
  input wire logic run,
  input wire logic dual,
  input wire logic [15:0] word,
  input wire logic copo,
  input wire logic copo_oe,
  input wire logic lane0_out,
  input wire logic lane0_oe,
  input wire logic lane1_out,
  input wire logic lane1_oe,
  output logic sclk,
  output logic cipo,
  output logic lane0,
  output logic lane1,
  output logic [15:0] seen
);
  initial begin
    sclk = 1'b0;
    cipo = 1'b0;
    lane0 = 1'b1;
    lane1 = 1'b0;
    seen = 16'h0000;
    forever begin
      @(posedge run);
      // Keep link edges off the system clock edge
      #5;
      // MSB first, two bits per clock in dual
      for (int i = 15; i >= 0; i -= (dual ? 2 : 1)) begin
        cipo = word[i];
        lane1 = word[i];
        lane0 = dual ? word[i - 1] : 1'b0;
        // link clock well below the top rate
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
        if (dual) seen = {seen[13:0], lane1_out & lane1_oe, lane0_out & lane0_oe};
        else seen = {seen[14:0], copo & copo_oe};
      end
      cipo = ~cipo;
      lane0 = ~lane0;
      lane1 = ~lane1;
    end
  end
endmodule : spi_fmt_partner

/* spi_fmt_pkg.sv */
// Types shared by the format block
package spi_fmt_pkg;
  typedef enum {
    XF_IDLE,
    XF_SHIFT,
    XF_DONE
  } xfer_state_t;
  typedef enum logic [1:0] {
    WIRE_FOUR,
    WIRE_THREE,
    WIRE_DUAL
  } wire_mode_t;
endpackage : spi_fmt_pkg

/* spi_fmt_top.sv */
// SPI format and line configuration with Wishbone registers
`timescale 1ns/1ns
`include "spi_fmt_params.svh"
module spi_fmt_top
  import spi_fmt_pkg::*;
#(
  parameter int NUM_SELECTS = 4,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_WORDS
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SCLK_FB,
  input wire logic CIPO,
  input wire logic LANE0_IN,
  input wire logic LANE1_IN,
  output logic COPO,
  output logic COPO_OE,
  output logic LANE0_OUT,
  output logic LANE0_OE,
  output logic LANE1_OUT,
  output logic LANE1_OE,
  output logic [NUM_SELECTS-1:0] SELECT_OUT
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] clk_sync;
    logic [1:0] cipo_sync;
    logic [1:0] l0_sync;
    logic [1:0] l1_sync;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] control;
    logic [31:0] counts;
    logic [31:0] format;
    logic [15:0] shift_tx;
    logic [15:0] shift_rx;
    logic [15:0] rx_word;
    logic [4:0] bits_left;
    logic [15:0] chars_left;
    logic active;
    logic copo;
    logic copo_oe;
    logic l0;
    logic l0_oe;
    logic l1;
    logic l1_oe;
    logic [NUM_SELECTS-1:0] sel;
    xfer_state_t xs;
  } top_st_t;
  top_st_t st_q;
  top_st_t st_d;
  logic rst_n;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic fifo_push;
  logic [4:0] char_len;
  logic fb_rise;
  wire_mode_t wmode;
  logic ctl_mode;
  logic fb_eff;
  logic fb_prev;
  logic count_wr;
  initial begin
    if (NUM_SELECTS != 4) $error("Select polarity field holds four lines");
  end
  assign rst_n = st_q.rst_sync[1];
  assign ctl_mode = st_q.control[`CTL_MODE_BIT];
  assign char_len = (st_q.format[`FMT_CHAR_HI:`FMT_CHAR_LO] == 4'h0) ? `CHAR_LEN_ZERO_BITS
                    : {1'b0, st_q.format[`FMT_CHAR_HI:`FMT_CHAR_LO]};
  always_comb begin
    if (st_q.format[`FMT_LANES_HI:`FMT_LANES_LO] == `LANES_DUAL) begin
      wmode = WIRE_DUAL;
    end else if (st_q.format[`FMT_ONE_LINE_BIT]) begin
      wmode = WIRE_THREE;
    end else begin
      wmode = WIRE_FOUR;
    end
  end
  assign fb_eff = st_q.clk_sync[1] ^ (ctl_mode & st_q.format[`FMT_FB_INV_BIT]);
  assign fb_prev = st_q.clk_sync[2] ^ (ctl_mode & st_q.format[`FMT_FB_INV_BIT]);
  assign fb_rise = fb_eff && !fb_prev;
  assign fifo_push = WB_CYC_I && WB_STB_I && WB_WE_I && !st_q.ack
                     && WB_ADR_I == `ADDR_STATUS && fifo_in_ready;
  assign count_wr = WB_CYC_I && WB_STB_I && WB_WE_I && !st_q.ack
                    && WB_ADR_I == `ADDR_XFER_COUNT;
  // Hold the FIFO while a count load takes the idle cycle
  assign fifo_out_ready = st_q.xs == XF_IDLE && st_q.chars_left != 16'h0000 && !count_wr;
  spi_fmt_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(WB_DAT_I[15:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  always_comb begin
    st_d = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
    st_d.clk_sync = {st_q.clk_sync[1:0], SCLK_FB};
    st_d.cipo_sync = {st_q.cipo_sync[0], CIPO};
    st_d.l0_sync = {st_q.l0_sync[0], LANE0_IN};
    st_d.l1_sync = {st_q.l1_sync[0], LANE1_IN};
    st_d.ack = 1'b0;
    if (WB_CYC_I && WB_STB_I && !st_q.ack) begin
      st_d.ack = 1'b1;
      st_d.rdata = 32'h00000000;
      case (WB_ADR_I)
        `ADDR_CONTROL: begin
          st_d.rdata = st_q.control;
          if (WB_WE_I && WB_SEL_I[0]) st_d.control[7:0] = {6'h00, WB_DAT_I[1:0]};
        end
        `ADDR_XFER_COUNT: begin
          st_d.rdata = st_q.counts;
          for (int b = 0; b < 4; b++) begin
            if (WB_WE_I && WB_SEL_I[b]) st_d.counts[b*8 +: 8] = WB_DAT_I[b*8 +: 8];
          end
        end
        `ADDR_FORMAT: begin
          st_d.rdata = st_q.format;
          for (int b = 0; b < 4; b++) begin
            if (WB_WE_I && WB_SEL_I[b]) begin
              st_d.format[b*8 +: 8] = WB_DAT_I[b*8 +: 8] & 8'(`FMT_WRITE_MASK >> (b*8));
            end
          end
        end
        `ADDR_STATUS: begin
          st_d.rdata = {14'h0000, st_q.active, fifo_in_ready, st_q.rx_word};
        end
        default: begin
          st_d.rdata = 32'h00000000;
        end
      endcase
    end
    for (int i = 0; i < NUM_SELECTS; i++) begin
      st_d.sel[i] = st_q.format[`FMT_POL_LO + i] ? st_q.active : !st_q.active;
    end
    case (st_q.xs)
      XF_IDLE: begin
        st_d.active = 1'b0;
        st_d.copo_oe = 1'b0;
        st_d.l0_oe = 1'b0;
        st_d.l1_oe = 1'b0;
        if (count_wr) begin
          st_d.chars_left = (wmode == WIRE_FOUR || WB_DAT_I[31:16] == 16'h0000)
                            ? WB_DAT_I[15:0] : WB_DAT_I[31:16];
        end else if (fifo_out_ready && fifo_out_valid) begin
          st_d.shift_tx = fifo_out_data << (5'h10 - char_len);
          // Short characters read back with zero upper bits
          st_d.shift_rx = 16'h0000;
          st_d.bits_left = char_len;
          st_d.active = 1'b1;
          st_d.xs = XF_SHIFT;
        end
      end
      XF_SHIFT: begin
        if (fb_rise) begin
          case (wmode)
            WIRE_DUAL: begin
              // two bits per clock on both lanes
              st_d.l1 = st_q.shift_tx[15];
              st_d.l0 = st_q.shift_tx[14];
              st_d.l0_oe = 1'b1;
              st_d.l1_oe = 1'b1;
              st_d.shift_tx = {st_q.shift_tx[13:0], 2'h0};
              st_d.shift_rx = {st_q.shift_rx[13:0], st_q.l1_sync[1], st_q.l0_sync[1]};
              st_d.bits_left = (st_q.bits_left > 5'h2) ? st_q.bits_left - 5'h2 : 5'h0;
            end
            WIRE_THREE: begin
              st_d.copo = st_q.shift_tx[15];
              st_d.copo_oe = ctl_mode;
              st_d.shift_tx = {st_q.shift_tx[14:0], 1'b0};
              st_d.shift_rx = {st_q.shift_rx[14:0], st_q.copo};
              st_d.bits_left = st_q.bits_left - 5'h1;
            end
            default: begin
              st_d.copo = st_q.shift_tx[15];
              st_d.copo_oe = 1'b1;
              st_d.shift_tx = {st_q.shift_tx[14:0], 1'b0};
              st_d.shift_rx = {st_q.shift_rx[14:0], st_q.cipo_sync[1]};
              st_d.bits_left = st_q.bits_left - 5'h1;
            end
          endcase
          if (st_d.bits_left == 5'h0) st_d.xs = XF_DONE;
        end
      end
      XF_DONE: begin
        st_d.rx_word = st_q.shift_rx;
        st_d.chars_left = st_q.chars_left - 16'h0001;
        st_d.xs = XF_IDLE;
      end
      default: begin
        st_d.xs = XF_IDLE;
      end
    endcase
  end
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= '0;
      st_q.sel <= '1;
      st_q.xs <= XF_IDLE;
    end else if (!rst_n) begin
      st_q <= '0;
      st_q.rst_sync <= st_d.rst_sync;
      st_q.sel <= '1;
      st_q.xs <= XF_IDLE;
    end else begin
      st_q <= st_d;
    end
  end
  assign WB_DAT_O = st_q.rdata;
  assign WB_ACK_O = st_q.ack;
  assign COPO = st_q.copo;
  assign COPO_OE = st_q.copo_oe;
  assign LANE0_OUT = st_q.l0;
  assign LANE0_OE = st_q.l0_oe;
  assign LANE1_OUT = st_q.l1;
  assign LANE1_OE = st_q.l1_oe;
  assign SELECT_OUT = st_q.sel;
endmodule : spi_fmt_top

/* spi_fmt_top_tb_top.sv */
// Self-checking bench for the format block
`timescale 1ns/1ns
`include "spi_fmt_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module spi_fmt_top_tb_top;
  logic mclk, nrst, cyc, stb, we, run, ack, sclk, cipo, l0, l1;
  logic pdual, copo, copo_oe, l0o, l0oe, l1o, l1oe;
  logic [15:0] pword, seen;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel_out;
  int num_errors = 0;
  int checks_done = 0;
  logic [67:0] rows [4] = '{{32'hffffffff, 32'h000fbf10, 4'h0},
    {32'h00051a08, 32'h00051a00, 4'ha}, {32'h0000830c, 32'h00008300, 4'hf},
    {32'h000a0f00, 32'h000a0f00, 4'h5}};
  spi_fmt_top dut (.MCLK(mclk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SCLK_FB(sclk), .CIPO(cipo), .LANE0_IN(l0), .LANE1_IN(l1), .COPO(copo),
    .COPO_OE(copo_oe), .LANE0_OUT(l0o), .LANE0_OE(l0oe), .LANE1_OUT(l1o), .LANE1_OE(l1oe),
    .SELECT_OUT(sel_out));
  spi_fmt_partner far (.run(run), .dual(pdual), .word(pword), .copo(copo),
    .copo_oe(copo_oe), .lane0_out(l0o), .lane0_oe(l0oe), .lane1_out(l1o), .lane1_oe(l1oe),
    .sclk(sclk), .cipo(cipo), .lane0(l0), .lane1(l1), .seen(seen));
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : do_reset
  task automatic run_link(input logic d, input logic [15:0] w);
    pdual <= d;
    pword <= w;
    run <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      wb(0, `ADDR_STATUS, 0);
      if (q[17] === 1'b0) break;
    end
    `CHK("link done", 1'b0, q[17])
    if (q[17] !== 1'b0) stop_test();
    run <= 1'b0;
  endtask : run_link
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {nrst, cyc, stb, we, run, adr, wdat, pdual, pword} = '0;
    do_reset();
    wb(0, `ADDR_FORMAT, 0);
    `CHK("fmt reset", 32'h0, q)
    `CHK("sel reset", 4'hf, sel_out)
    for (int i = 0; i < 4; i++) begin
      wb(1, `ADDR_FORMAT, rows[i][67:36]);
      wb(0, `ADDR_FORMAT, 0);
      `CHK("fmt read", rows[i][35:4], q)
      `CHK("sel idle", rows[i][3:0], sel_out)
    end
    wb(1, 8'h20, 32'hffffffff);
    wb(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, q)
    wb(1, `ADDR_FORMAT, 0);
    wb(1, `ADDR_CONTROL, 32'h2);
    wb(1, `ADDR_XFER_COUNT, 32'h00050001);
    for (int i = 0; i < 6; i++) wb(1, `ADDR_STATUS, 32'h1230 + i);
    wb(0, `ADDR_STATUS, 0);
    `CHK("fifo full", 1'b0, q[16])
    run_link(1'b0, 16'hc35a);
    `CHK("rx char", 16'hc35a, q[15:0])
    `CHK("tx char", 16'h1230, seen)
    wb(1, `ADDR_FORMAT, 32'h00009000);
    wb(1, `ADDR_XFER_COUNT, 32'h00000001);
    run_link(1'b1, 16'h5ac3);
    `CHK("dual rx", 16'h5ac3, q[15:0])
    `CHK("dual tx", 16'h1231, seen)
    // three-wire sends on the output line
    wb(1, `ADDR_FORMAT, 32'h00008000);
    wb(1, `ADDR_XFER_COUNT, 32'h00000001);
    run_link(1'b0, 16'h0000);
    `CHK("three tx", 16'h1232, seen)
    wb(1, `ADDR_FORMAT, 32'h000f8f10);
    do_reset();
    wb(0, `ADDR_FORMAT, 0);
    `CHK("fmt rereset", 32'h0, q)
    `CHK("sel rereset", 4'hf, sel_out)
    stop_test();
  end
endmodule : spi_fmt_top_tb_top
